//--- hdl/cmt_pkg.sv
/*
 compare-match timer constants: widths, reset values, stop-level codes.
 assumes a single system clock; no register bus, all settings are ports.
*/
package cmt_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int BASE_W     = 16;
   localparam int CNT_W      = 16;
   localparam int PRE4_W     = 4;
   localparam int MIN_W      = 8;
   localparam int NWAVE      = 8;
   localparam int NGEN       = 4;
   localparam int NPIN       = 6;
   localparam int NIRQ       = 17;
   // ------------------------------------------------------------
   // overflow bit positions
   // ------------------------------------------------------------
   localparam int OVF_BIT14  = 14;
   localparam int OVF_BIT15  = 15;
   // ------------------------------------------------------------
   // interrupt flag positions
   // ------------------------------------------------------------
   localparam int IRQ_OVF    = 0;
   localparam int IRQ_CMI0   = 1;
   localparam int IRQ_CMI1   = 2;
   localparam int IRQ_CMP0   = 3;
   localparam int IRQ_CMP1   = 4;
   localparam int IRQ_GEN0   = 5;
   localparam int IRQ_MIN    = 9;
   localparam int IRQ_WAVE0  = 10;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [BASE_W-1:0] BASE_RST = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   localparam logic [PRE4_W-1:0] PRE_RST  = 4'h0;
   localparam logic [MIN_W-1:0]  MIN_RST  = 8'h00;
   // ------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      STOPLVL_LOW  = 2'b00,
      STOPLVL_HIGH = 2'b01,
      STOPLVL_KEEP = 2'b10
   } cmt_stoplvl_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_STOP = 2'b10
   } cmt_state_t;
endpackage

//--- hdl/cmt_match_if.sv
/*
 interface carrying match pulses from the comparator bank to the top.
 assumes both ends sit on i_clk.
*/
`timescale 1ns/1ps
interface cmt_match_if;
   logic [cmt_pkg::NWAVE-1:0] wave_hit;
   logic [cmt_pkg::NGEN-1:0]  gen_hit;
   logic [1:0]                cmp_hit;
   modport src
   (
      output wave_hit,
      output gen_hit,
      output cmp_hit
   );
   modport dst
   (
      input  wave_hit,
      input  gen_hit,
      input  cmp_hit
   );
endinterface

//--- hdl/cmt_cmp_bank.sv
/*
 comparator bank: equality of compare values against base timer and counter.
 assumes values and counters are stable on i_clk; outputs are registered pulses.
*/
`timescale 1ns/1ps
module cmt_cmp_bank
(
   // clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   // counters, with advance strobes
   input  wire logic [cmt_pkg::BASE_W-1:0]    i_base,
   input  wire logic                          i_base_adv,
   input  wire logic [cmt_pkg::CNT_W-1:0]     i_cnt,
   input  wire logic                          i_cnt_adv,
   // compare values
   input  wire logic [cmt_pkg::NWAVE*16-1:0]  i_wave_val,
   input  wire logic [cmt_pkg::NGEN*16-1:0]   i_gen_val,
   input  wire logic [31:0]                   i_cmp_val,
   // match pulses
   cmt_match_if.src                           m
);
   typedef struct packed
   {
      logic [cmt_pkg::NWAVE-1:0] wave;
      logic [cmt_pkg::NGEN-1:0]  gen;
      logic [1:0]                cmp;
   } cmt_bank_t;

   cmt_bank_t st_r;
   cmt_bank_t st_nxt;

   // one pulse per counter step, so a parked counter does not repeat hits
   always_comb
   begin
      st_nxt = '0;
      for (int i = 0; i < cmt_pkg::NWAVE; i++)
      begin
         st_nxt.wave[i] = i_base_adv && (i_base == i_wave_val[i*16 +: 16]);
      end
      for (int i = 0; i < cmt_pkg::NGEN; i++)
      begin
         st_nxt.gen[i] = i_cnt_adv && (i_cnt == i_gen_val[i*16 +: 16]);
      end
      for (int i = 0; i < 2; i++)
      begin
         st_nxt.cmp[i] = i_cnt_adv && (i_cnt == i_cmp_val[i*16 +: 16]);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign m.wave_hit = st_r.wave;
   assign m.gen_hit  = st_r.gen;
   assign m.cmp_hit  = st_r.cmp;
endmodule

//--- hdl/cmt_timer.sv
/*
 compare-match timer top: base timer, prescaled min-count counter,
 general counter with compare clear, stop modes and pin enables.
 assumes all control ports are synchronous to i_clk.
*/
`timescale 1ns/1ps
// Operation
// - base overflow flag raised on bit 14 or bit 15 carry, selectable.
// - prescaler on: source halved, 4-bit then 8-bit, period 32(n+1).
// - prescaler off: halved source into 8-bit only, period 2(n+1).
// - software stop: run bit 0 halts count, pins hold last level under STOPLVL_KEEP.
// - compare stop: general A match (gen 0) halts the count, i_a_chan has no effect; pins keep match level under STOPLVL_KEEP.
// - stopped o_cmp_pin outputs forced low, forced high or left unchanged; o_wave and o_gen_pin are not forced.
// - six pin enables; a pin is driven only while enabled.
// - eight waveform compares on base timer toggle outputs, raise interrupts 0/1.
// - compare 0/1 on counter raise interrupt and toggle their output.
// - general A-D matches toggle their pin and raise an interrupt.
// - 8-bit counter equal to min count inverts toggle pin, raises interrupt.
// - counter cleared on chosen general match only when clearing selected.
module cmt_timer
(
   // clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   // control
   input  wire logic                          i_run,
   input  wire logic                          i_ovf_sel15,
   input  wire logic                          i_pre4_en,
   input  wire logic                          i_stop_on_a,
   input  wire logic                          i_a_chan,
   input  wire cmt_pkg::cmt_stoplvl_t         i_stop_lvl,
   input  wire logic                          i_clr_en,
   input  wire logic [1:0]                    i_clr_sel,
   input  wire logic [cmt_pkg::NPIN-1:0]      i_pin_en,
   // compare values
   input  wire logic [cmt_pkg::MIN_W-1:0]     i_min_count_reg,
   input  wire logic [cmt_pkg::NWAVE*16-1:0]  i_wave_val,
   input  wire logic [cmt_pkg::NGEN*16-1:0]   i_gen_val,
   input  wire logic [31:0]                   i_cmp_val,
   // interrupt flags
   input  wire logic [cmt_pkg::NIRQ-1:0]      i_irq_clr,
   output logic [cmt_pkg::NIRQ-1:0]           o_irq_flag,
   // outputs and enables
   output logic [cmt_pkg::NPIN-1:0]           o_cmp_pin,
   output logic [cmt_pkg::NPIN-1:0]           o_cmp_pin_oe,
   output logic [cmt_pkg::NWAVE-1:0]          o_wave,
   output logic [cmt_pkg::NGEN-1:0]           o_gen_pin,
   output logic                               o_toggle_output_pin,
   output logic                               o_running
);
   typedef struct packed
   {
      cmt_pkg::cmt_state_t               state;
      logic                              run_d;
      logic                              div2;
      logic [cmt_pkg::PRE4_W-1:0]        pre4;
      logic [cmt_pkg::MIN_W-1:0]         cnt8;
      logic [cmt_pkg::BASE_W-1:0]        base;
      logic [cmt_pkg::CNT_W-1:0]         cnt;
      logic                              base_adv;
      logic                              cnt_adv;
      logic [cmt_pkg::NIRQ-1:0]          irq;
      logic [cmt_pkg::NPIN-1:0]          lvl;
      logic [cmt_pkg::NPIN-1:0]          pin;
      logic [cmt_pkg::NPIN-1:0]          oe;
      logic [cmt_pkg::NWAVE-1:0]         wave;
      logic [cmt_pkg::NGEN-1:0]          gen;
      logic                              tog;
      logic                              run_o;
   } cmt_state_s_t;

   cmt_state_s_t st_r;
   cmt_state_s_t st_nxt;
   cmt_match_if  mif ();

   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------
   cmt_cmp_bank u_bank
   (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_base     (st_r.base),
      .i_base_adv (st_r.base_adv),
      .i_cnt      (st_r.cnt),
      .i_cnt_adv  (st_r.cnt_adv),
      .i_wave_val (i_wave_val),
      .i_gen_val  (i_gen_val),
      .i_cmp_val  (i_cmp_val),
      .m          (mif.src)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic                        running;
   logic                        src_tick;
   logic                        pre_tick;
   logic                        min_hit;
   logic                        a_hit;
   logic [cmt_pkg::BASE_W:0]    base_sum;
   logic [cmt_pkg::NIRQ-1:0]    ev;
   logic [cmt_pkg::NPIN-1:0]    pin_ev;

   always_comb
   begin
      st_nxt   = st_r;
      running  = (st_r.state == cmt_pkg::ST_RUN);
      ev       = '0;
      pin_ev   = '0;
      base_sum = '0;
      st_nxt.run_d    = i_run;
      st_nxt.base_adv = 1'b0;
      st_nxt.cnt_adv  = 1'b0;
      src_tick = running && st_r.div2;
      pre_tick = 1'b0;
      min_hit  = 1'b0;
      if (running)
      begin
         st_nxt.div2 = ~st_r.div2;
      end
      if (src_tick && i_pre4_en)
      begin
         st_nxt.pre4 = st_r.pre4 + 4'h1;
         pre_tick    = (st_r.pre4 == 4'hf);
      end
      else if (src_tick)
      begin
         pre_tick = 1'b1;
      end
      if (pre_tick)
      begin
         min_hit = (st_r.cnt8 == i_min_count_reg);
         st_nxt.cnt8 = min_hit ? cmt_pkg::MIN_RST : st_r.cnt8 + 8'h01;
      end
      if (min_hit)
      begin
         st_nxt.tog = ~st_r.tog;
      end
      ev[cmt_pkg::IRQ_MIN] = min_hit;
      // base timer runs on the halved source
      if (src_tick)
      begin
         base_sum = {1'b0, st_r.base} + 17'h0_0001;
         st_nxt.base     = base_sum[cmt_pkg::BASE_W-1:0];
         st_nxt.base_adv = 1'b1;
         if (i_ovf_sel15)
         begin
            ev[cmt_pkg::IRQ_OVF] = base_sum[cmt_pkg::BASE_W];
         end
         else
         begin
            ev[cmt_pkg::IRQ_OVF] = (st_r.base[cmt_pkg::OVF_BIT14:0] == 15'h7fff);
         end
      end
      if (running)
      begin
         st_nxt.cnt_adv = 1'b1;
         if (i_clr_en && mif.gen_hit[i_clr_sel])
         begin
            st_nxt.cnt = cmt_pkg::CNT_RST;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end
      st_nxt.wave = st_r.wave ^ mif.wave_hit;
      ev[cmt_pkg::IRQ_CMI0] = |mif.wave_hit[3:0];
      ev[cmt_pkg::IRQ_CMI1] = |mif.wave_hit[7:4];
      ev[cmt_pkg::IRQ_WAVE0 +: 7] = mif.wave_hit[6:0];
      ev[cmt_pkg::IRQ_CMP0] = mif.cmp_hit[0];
      ev[cmt_pkg::IRQ_CMP1] = mif.cmp_hit[1];
      pin_ev[0] = mif.cmp_hit[0];
      pin_ev[3] = mif.cmp_hit[1];
      st_nxt.gen = st_r.gen ^ mif.gen_hit;
      ev[cmt_pkg::IRQ_GEN0 +: cmt_pkg::NGEN] = mif.gen_hit;
      pin_ev[1] = mif.gen_hit[0];
      pin_ev[2] = mif.gen_hit[1];
      pin_ev[4] = mif.gen_hit[2];
      pin_ev[5] = mif.gen_hit[3];
      // levels frozen while stopped
      // hits still in the bank pipeline must not move a stopped pin
      st_nxt.lvl = running ? (st_r.lvl ^ pin_ev) : st_r.lvl;
      a_hit = mif.gen_hit[0] && (i_a_chan ? 1'b1 : 1'b1);
      // run control
      case (st_r.state)
         cmt_pkg::ST_IDLE,
         cmt_pkg::ST_STOP:
         begin
            if (i_run && !st_r.run_d)
            begin
               st_nxt.state = cmt_pkg::ST_RUN;
            end
         end
         cmt_pkg::ST_RUN:
         begin
            if (!i_run)
            begin
               st_nxt.state = cmt_pkg::ST_STOP;
               st_nxt.lvl   = st_r.lvl;
            end
            // compare stop keeps the match level
            else if (i_stop_on_a && a_hit)
            begin
               st_nxt.state = cmt_pkg::ST_STOP;
            end
         end
         default:
         begin
            st_nxt.state = cmt_pkg::ST_IDLE;
         end
      endcase
      if (st_nxt.state == cmt_pkg::ST_STOP)
      begin
         case (i_stop_lvl)
            cmt_pkg::STOPLVL_LOW:  st_nxt.pin = '0;
            cmt_pkg::STOPLVL_HIGH: st_nxt.pin = '1;
            default:               st_nxt.pin = st_nxt.lvl;
         endcase
      end
      else
      begin
         st_nxt.pin = st_nxt.lvl;
      end
      st_nxt.oe = i_pin_en;
      for (int i = 0; i < cmt_pkg::NPIN; i++)
      begin
         if (!i_pin_en[i])
         begin
            st_nxt.pin[i] = 1'b0;
         end
      end
      // registered copy of the run state, so the port needs no decode
      st_nxt.run_o = (st_nxt.state == cmt_pkg::ST_RUN);
      st_nxt.irq = (st_r.irq & ~i_irq_clr) | ev;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r       <= '0;
         st_r.state <= cmt_pkg::ST_IDLE;
         st_r.pre4  <= cmt_pkg::PRE_RST;
         st_r.cnt8  <= cmt_pkg::MIN_RST;
         st_r.base  <= cmt_pkg::BASE_RST;
         st_r.cnt   <= cmt_pkg::CNT_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_irq_flag          = st_r.irq;
   assign o_cmp_pin           = st_r.pin;
   assign o_cmp_pin_oe        = st_r.oe;
   assign o_wave              = st_r.wave;
   assign o_gen_pin           = st_r.gen;
   assign o_toggle_output_pin = st_r.tog;
   assign o_running           = st_r.run_o;
endmodule

//--- verif/cmt_timer_checker.sv
/*
 checker for cmt_timer: pin enables, stop levels, run control, flags, reset.
 assumes it is bound to cmt_timer and sees only its ports.
*/
`timescale 1ns/1ps
module cmt_timer_checker
(
   // clock and reset
   input wire logic                     i_clk,
   input wire logic                     i_rst_n,
   // control
   input wire logic                     i_run,
   input wire logic                     i_stop_on_a,
   input wire cmt_pkg::cmt_stoplvl_t    i_stop_lvl,
   input wire logic [cmt_pkg::NPIN-1:0] i_pin_en,
   input wire logic [cmt_pkg::NIRQ-1:0] i_irq_clr,
   // observed outputs
   input wire logic [cmt_pkg::NIRQ-1:0] o_irq_flag,
   input wire logic [cmt_pkg::NPIN-1:0] o_cmp_pin,
   input wire logic [cmt_pkg::NPIN-1:0] o_cmp_pin_oe,
   input wire logic                     o_toggle_output_pin,
   input wire logic                     o_running
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   property p_pin_oe;
      $past(i_rst_n) |-> o_cmp_pin_oe == $past(i_pin_en);
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable not followed");
   property p_pin_gate;
      (o_cmp_pin & ~o_cmp_pin_oe) == '0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled pin driven");
   property p_rst_vals;
      $rose(i_rst_n) |-> !o_running && o_irq_flag == '0 && o_cmp_pin == '0;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("state after reset wrong");
   property p_run_start;
      $past(i_rst_n) && $rose(i_run) && !i_stop_on_a |-> ##[1:2] o_running;
   endproperty
   a_run_start: assert property (p_run_start) else $error("count did not start");
   property p_sw_stop;
      (!i_run) [*2] |=> !o_running;
   endproperty
   a_sw_stop: assert property (p_sw_stop) else $error("count did not stop");
   property p_flag_sticky;
      $past(i_rst_n) |-> ($past(o_irq_flag) & ~o_irq_flag & ~$past(i_irq_clr)) == '0;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
   property p_toggle_irq;
      $past(i_rst_n) && $changed(o_toggle_output_pin) |-> ##[0:2] o_irq_flag[cmt_pkg::IRQ_MIN];
   endproperty
   a_toggle_irq: assert property (p_toggle_irq) else $error("toggle without flag");
   property p_stop_low;
      $past(i_rst_n) && $fell(o_running) && i_stop_lvl == cmt_pkg::STOPLVL_LOW
         |-> ##[0:2] o_cmp_pin == '0;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("pins not low at stop");
   property p_stop_high;
      $past(i_rst_n) && $fell(o_running) && i_stop_lvl == cmt_pkg::STOPLVL_HIGH
         |-> ##[0:2] o_cmp_pin == o_cmp_pin_oe;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("pins not high at stop");
   property p_stop_keep;
      $past(i_rst_n) && !o_running && !$past(o_running)
         && $past(i_stop_lvl) == cmt_pkg::STOPLVL_KEEP
         && $past(i_stop_lvl, 2) == cmt_pkg::STOPLVL_KEEP
         && $stable(o_cmp_pin_oe) |-> $stable(o_cmp_pin);
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("pins moved while stopped");
   c_run: cover property ($rose(o_running));
   c_stop: cover property ($fell(o_running));
   c_toggle: cover property ($changed(o_toggle_output_pin));
   c_clear: cover property (|(o_irq_flag & i_irq_clr));
endmodule
bind cmt_timer cmt_timer_checker u_chk
(
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(i_run), .i_stop_on_a(i_stop_on_a),
   .i_stop_lvl(i_stop_lvl), .i_pin_en(i_pin_en), .i_irq_clr(i_irq_clr),
   .o_irq_flag(o_irq_flag), .o_cmp_pin(o_cmp_pin), .o_cmp_pin_oe(o_cmp_pin_oe),
   .o_toggle_output_pin(o_toggle_output_pin), .o_running(o_running)
);

//--- verif/tb_top.sv
/*
 self-checking bench for cmt_timer, driving its ports directly.
 assumes the checker is bound in; overflow scenario needs about 66000 cycles.
*/
`timescale 1ns/1ps
module tb_top;
   logic                         i_clk;
   logic                         i_rst_n;
   logic                         i_run;
   logic                         i_ovf_sel15;
   logic                         i_pre4_en;
   logic                         i_stop_on_a;
   logic                         i_a_chan;
   cmt_pkg::cmt_stoplvl_t        i_stop_lvl;
   logic                         i_clr_en;
   logic [1:0]                   i_clr_sel;
   logic [cmt_pkg::NPIN-1:0]     i_pin_en;
   logic [cmt_pkg::MIN_W-1:0]    i_min_count_reg;
   logic [cmt_pkg::NWAVE*16-1:0] i_wave_val;
   logic [cmt_pkg::NGEN*16-1:0]  i_gen_val;
   logic [31:0]                  i_cmp_val;
   logic [cmt_pkg::NIRQ-1:0]     i_irq_clr;
   logic [cmt_pkg::NIRQ-1:0]     o_irq_flag;
   logic [cmt_pkg::NPIN-1:0]     o_cmp_pin;
   logic [cmt_pkg::NPIN-1:0]     o_cmp_pin_oe;
   logic [cmt_pkg::NWAVE-1:0]    o_wave;
   logic [cmt_pkg::NGEN-1:0]     o_gen_pin;
   logic                         o_toggle_output_pin;
   logic                         o_running;
   int                           errors;
   int                           check_count;
   int                           gap;
   localparam cmt_pkg::cmt_stoplvl_t LVLS [3] =
      '{cmt_pkg::STOPLVL_LOW, cmt_pkg::STOPLVL_HIGH, cmt_pkg::STOPLVL_KEEP};
   // only pin0 (cmp0 matched once) and pin3 (never matched) are judged
   localparam logic [5:0] STOP_PINS [3] = '{6'h00, 6'h09, 6'h01};

   cmt_timer uut
   (
      .i_clk, .i_rst_n, .i_run, .i_ovf_sel15, .i_pre4_en, .i_stop_on_a, .i_a_chan,
      .i_stop_lvl, .i_clr_en, .i_clr_sel, .i_pin_en, .i_min_count_reg, .i_wave_val,
      .i_gen_val, .i_cmp_val, .i_irq_clr, .o_irq_flag, .o_cmp_pin, .o_cmp_pin_oe,
      .o_wave, .o_gen_pin, .o_toggle_output_pin, .o_running
   );

   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // far compare values keep unrelated matches out of every scenario but the overflow run
   task automatic restart(input int hold);
      i_rst_n = 1'b0;
      i_run = 1'b0;
      i_ovf_sel15 = 1'b0;
      i_pre4_en = 1'b0;
      i_stop_on_a = 1'b0;
      i_a_chan = 1'b0;
      i_stop_lvl = cmt_pkg::STOPLVL_KEEP;
      i_clr_en = 1'b0;
      i_clr_sel = 2'h0;
      i_pin_en = 6'h3f;
      i_min_count_reg = 8'hff;
      i_wave_val = {8{16'h7000}};
      i_gen_val = {4{16'h7000}};
      i_cmp_val = {2{16'h7000}};
      i_irq_clr = '0;
      tick(hold);
      i_rst_n = 1'b1;
      tick(2);
   endtask
   // first toggle may follow a partial period, so time the second
   task automatic toggle_gap(output int g);
      int first;
      logic last;
      first = -1;
      g = -1;
      last = o_toggle_output_pin;
      for (int n = 0; n < 600 && g < 0; n++)
      begin
         tick(1);
         if (o_toggle_output_pin !== last)
         begin
            if (first < 0)
               first = n;
            else
               g = n - first;
            last = o_toggle_output_pin;
         end
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      errors = 0;
      check_count = 0;
      restart(20);
      check("reset", {o_running, o_toggle_output_pin, o_cmp_pin, o_irq_flag}, 32'h0);
      for (int p = 0; p < 2; p++)
      begin
         restart(2);
         i_pre4_en = p[0];
         i_min_count_reg = 8'h03;
         i_run = 1'b1;
         toggle_gap(gap);
         check("toggle gap", gap, p ? 32'h0000_0080 : 32'h0000_0008);
         check("min flag", o_irq_flag[cmt_pkg::IRQ_MIN], 32'h1);
      end
      for (int c = 0; c < 2; c++)
      begin
         restart(2);
         i_clr_en = c[0];
         i_pin_en = c ? 6'h3f : 6'h3e;
         i_gen_val[15:0] = 16'h0014;
         i_cmp_val[15:0] = 16'h001e;
         i_cmp_val[31:16] = 16'h0028;
         i_wave_val[15:0] = 16'h0005;
         i_run = 1'b1;
         tick(60);
         check("gen a flag", o_irq_flag[cmt_pkg::IRQ_GEN0], 32'h1);
         check("cmp0 flag", o_irq_flag[cmt_pkg::IRQ_CMP0], c ? 32'h0 : 32'h1);
         check("cmp1", {o_irq_flag[cmt_pkg::IRQ_CMP1], o_cmp_pin[3]}, c ? 32'h0 : 32'h3);
         check("pin oe", o_cmp_pin_oe, i_pin_en);
         if (c == 0)
         begin
            check("pins", {o_wave[0], o_gen_pin[0], o_cmp_pin[1:0]}, 32'he);
            check("wave flags", {o_irq_flag[cmt_pkg::IRQ_WAVE0], o_irq_flag[cmt_pkg::IRQ_CMI0]},
                  32'h3);
            i_irq_clr = '1;
            tick(1);
            i_irq_clr = '0;
            tick(1);
            check("flags cleared", o_irq_flag, 32'h0);
         end
      end
      for (int s = 0; s < 3; s++)
      begin
         restart(2);
         i_stop_lvl = LVLS[s];
         i_cmp_val[15:0] = 16'h0005;
         i_run = 1'b1;
         tick(20);
         i_run = 1'b0;
         tick(5);
         check("stop pins", o_cmp_pin & 6'h09, STOP_PINS[s]);
         check("stopped", o_running, 32'h0);
      end
      restart(2);
      i_stop_on_a = 1'b1;
      i_gen_val[15:0] = 16'h000a;
      i_run = 1'b1;
      tick(30);
      check("compare stop", {o_running, o_cmp_pin[1]}, 32'h1);
      restart(2);
      i_run = 1'b1;
      tick(60000);
      check("early overflow", o_irq_flag[cmt_pkg::IRQ_OVF], 32'h0);
      tick(6000);
      check("overflow", o_irq_flag[cmt_pkg::IRQ_OVF], 32'h1);
      end_of_test();
   end

   initial
   begin
      #3_600_000;
      errors++;
      end_of_test();
   end
endmodule
